/* core/dbgp_pkg.sv */
// Constants shared by the debug processor and bus master ports.
// Assumes one system clock; all request ports come from same-clock logic.
package dbgp_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	// Fixed cycle-type attributes: classic single cycle, linear burst type
	localparam logic CAB_FIXED = 1'b0;
	localparam logic [2:0] CTI_CLASSIC = 3'h0;
	localparam logic [1:0] BTE_LINEAR = 2'h0;
	typedef enum logic [1:0] {
		DBGP_IDLE = 2'b00,
		DBGP_BUSY = 2'b01,
		DBGP_DONE = 2'b11
	} dbgp_state_t;
endpackage

/* core/dbgp_bus_master.sv */
// Single-cycle bus master for debug memory access.
// Assumes a same-clock requester and a classic-cycle slave.
`timescale 1ns/1ps
module dbgp_bus_master (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Requester side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [dbgp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [dbgp_pkg::SEL_W-1:0] req_sel,
	input wire logic [dbgp_pkg::DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [dbgp_pkg::DATA_W-1:0] rsp_rdata,
	// Bus master side
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [dbgp_pkg::ADDR_W-1:0] wb_adr_o,
	output logic [dbgp_pkg::SEL_W-1:0] wb_sel_o,
	output logic [dbgp_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic [dbgp_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic wb_ack_i,
	input wire logic wb_err_i,
	output logic wb_cab_o,
	output logic [2:0] wb_cti_o,
	output logic [1:0] wb_bte_o
);
	dbgp_pkg::dbgp_state_t state_reg, state_next;
	logic we_reg, we_next;
	logic [dbgp_pkg::ADDR_W-1:0] adr_reg, adr_next;
	logic [dbgp_pkg::SEL_W-1:0] sel_reg, sel_next;
	logic [dbgp_pkg::DATA_W-1:0] dat_reg, dat_next;
	logic [dbgp_pkg::DATA_W-1:0] rd_reg, rd_next;
	logic err_reg, err_next;

	////////////////////////////////////////////////////////////////
	assign req_ready = (state_reg == dbgp_pkg::DBGP_IDLE);
	assign rsp_valid = (state_reg == dbgp_pkg::DBGP_DONE);
	assign rsp_err = err_reg;
	assign rsp_rdata = rd_reg;
	assign wb_cyc_o = (state_reg == dbgp_pkg::DBGP_BUSY);
	assign wb_stb_o = (state_reg == dbgp_pkg::DBGP_BUSY);
	assign wb_we_o = we_reg;
	assign wb_adr_o = adr_reg;
	assign wb_sel_o = sel_reg;
	assign wb_dat_o = dat_reg;
	assign wb_cab_o = dbgp_pkg::CAB_FIXED;
	assign wb_cti_o = dbgp_pkg::CTI_CLASSIC;
	assign wb_bte_o = dbgp_pkg::BTE_LINEAR;

	always_comb begin
		state_next = state_reg;
		we_next = we_reg;
		adr_next = adr_reg;
		sel_next = sel_reg;
		dat_next = dat_reg;
		rd_next = rd_reg;
		err_next = err_reg;
		case (state_reg)
			dbgp_pkg::DBGP_IDLE: begin
				if (req_valid) begin
					state_next = dbgp_pkg::DBGP_BUSY;
					we_next = req_write;
					adr_next = req_addr;
					sel_next = req_sel;
					dat_next = req_wdata;
				end
			end
			dbgp_pkg::DBGP_BUSY: begin
				// Attributes held until termination; one beat per cycle only
				if (wb_ack_i || wb_err_i) begin
					state_next = dbgp_pkg::DBGP_DONE;
					err_next = wb_err_i;
					rd_next = wb_dat_i;
				end
			end
			dbgp_pkg::DBGP_DONE: begin
				state_next = dbgp_pkg::DBGP_IDLE;
			end
			default: begin
				state_next = dbgp_pkg::DBGP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= dbgp_pkg::DBGP_IDLE;
			we_reg <= 1'b0;
			adr_reg <= dbgp_pkg::ADDR_ZERO;
			sel_reg <= dbgp_pkg::SEL_NONE;
			dat_reg <= dbgp_pkg::DATA_ZERO;
			rd_reg <= dbgp_pkg::DATA_ZERO;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			we_reg <= we_next;
			adr_reg <= adr_next;
			sel_reg <= sel_next;
			dat_reg <= dat_next;
			rd_reg <= rd_next;
			err_reg <= err_next;
		end
	end
endmodule // dbgp_bus_master

/* core/dbgp_ports.sv */
// Debug module processor port and system bus master port.
// Sections: stall, breakpoint indication, register access, bus master.
// Assumes processor and bus run on clk_sys; requests come from same-clock logic.
// Assumes the processor acknowledges every strobe and the bus slave ends every cycle.
//
// What this block does
// - Drive stall high to halt the processor; it stays halted while high.
// - Assert register strobe with register address to request a processor register access.
// - Write enable high with write data for writes, low for reads.
// - Act as a bus master issuing cycles to memories and peripherals.
// - Issue only single, non-burst bus cycles.
// - Assert cycle and strobe with address, selects, write enable; slave ends with ack or error.
// - Drive burst attribute outputs at fixed constant values.
`timescale 1ns/1ps
module dbgp_ports (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Stall control
	input wire logic stall_set,
	input wire logic stall_clear,
	output logic stall_active,
	output logic breakpoint_seen,
	// Processor register request
	input wire logic reg_req_valid,
	output logic reg_req_ready,
	input wire logic reg_req_write,
	input wire logic [dbgp_pkg::ADDR_W-1:0] reg_req_addr,
	input wire logic [dbgp_pkg::DATA_W-1:0] reg_req_wdata,
	output logic reg_rsp_valid,
	output logic [dbgp_pkg::DATA_W-1:0] reg_rsp_rdata,
	// Memory request
	input wire logic mem_req_valid,
	output logic mem_req_ready,
	input wire logic mem_req_write,
	input wire logic [dbgp_pkg::ADDR_W-1:0] mem_req_addr,
	input wire logic [dbgp_pkg::SEL_W-1:0] mem_req_sel,
	input wire logic [dbgp_pkg::DATA_W-1:0] mem_req_wdata,
	output logic mem_rsp_valid,
	output logic mem_rsp_err,
	output logic [dbgp_pkg::DATA_W-1:0] mem_rsp_rdata,
	// Processor debug port
	output logic cpu_stall,
	input wire logic cpu_breakpoint_hit,
	output logic cpu_stb,
	output logic cpu_we,
	output logic [dbgp_pkg::ADDR_W-1:0] cpu_adr,
	output logic [dbgp_pkg::DATA_W-1:0] cpu_dat_to,
	input wire logic [dbgp_pkg::DATA_W-1:0] cpu_dat_from,
	input wire logic cpu_ack,
	// System bus master port
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [dbgp_pkg::ADDR_W-1:0] wb_adr_o,
	output logic [dbgp_pkg::SEL_W-1:0] wb_sel_o,
	output logic [dbgp_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic [dbgp_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic wb_ack_i,
	input wire logic wb_err_i,
	output logic wb_cab_o,
	output logic [2:0] wb_cti_o,
	output logic [1:0] wb_bte_o
);
	logic stall_reg, stall_next;
	logic bp_reg, bp_next;
	dbgp_pkg::dbgp_state_t rstate_reg, rstate_next;
	logic rwe_reg, rwe_next;
	logic [dbgp_pkg::ADDR_W-1:0] radr_reg, radr_next;
	logic [dbgp_pkg::DATA_W-1:0] rdat_reg, rdat_next;
	logic [dbgp_pkg::DATA_W-1:0] rrd_reg, rrd_next;
	logic reg_idle;
	logic reg_busy;
	logic reg_done;

	////////////////////////////////////////////////////////////////
	// Stall
	// Stall is a level: the processor stays halted for as long as it is high
	assign cpu_stall = stall_reg;
	assign stall_active = stall_reg;

	always_comb begin
		stall_next = stall_reg;
		// Breakpoint wins over clear so the processor never runs past it
		if (stall_clear) begin
			stall_next = 1'b0;
		end
		if (stall_set || cpu_breakpoint_hit) begin
			stall_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stall_reg <= 1'b0;
		end else begin
			stall_reg <= stall_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Breakpoint indication
	// Status copy only; the stall register reacts on the same edge
	assign breakpoint_seen = bp_reg;

	always_comb begin
		bp_next = cpu_breakpoint_hit;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bp_reg <= 1'b0;
		end else begin
			bp_reg <= bp_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Processor register access
	// Ready only while idle: a request offered while busy is dropped, not queued
	assign reg_idle = (rstate_reg == dbgp_pkg::DBGP_IDLE);
	assign reg_busy = (rstate_reg == dbgp_pkg::DBGP_BUSY);
	assign reg_done = (rstate_reg == dbgp_pkg::DBGP_DONE);
	assign reg_req_ready = reg_idle;
	// Response trails ack by one cycle because the read data is registered
	assign reg_rsp_valid = reg_done;
	assign reg_rsp_rdata = rrd_reg;
	assign cpu_stb = reg_busy;
	assign cpu_we = rwe_reg;
	assign cpu_adr = radr_reg;
	assign cpu_dat_to = rdat_reg;

	always_comb begin
		rstate_next = rstate_reg;
		rwe_next = rwe_reg;
		radr_next = radr_reg;
		rdat_next = rdat_reg;
		rrd_next = rrd_reg;
		case (rstate_reg)
			dbgp_pkg::DBGP_IDLE: begin
				if (reg_req_valid) begin
					rstate_next = dbgp_pkg::DBGP_BUSY;
					rwe_next = reg_req_write;
					radr_next = reg_req_addr;
					// Zero on reads so no stale write data reaches the processor
					rdat_next = reg_req_write ? reg_req_wdata : dbgp_pkg::DATA_ZERO;
				end
			end
			dbgp_pkg::DBGP_BUSY: begin
				// No timeout: a silent processor holds the strobe forever
				if (cpu_ack) begin
					rstate_next = dbgp_pkg::DBGP_DONE;
					// Writes keep the last read data for the requester
					if (!rwe_reg) begin
						rrd_next = cpu_dat_from;
					end
				end
			end
			dbgp_pkg::DBGP_DONE: begin
				// One-cycle response, then ready again
				rstate_next = dbgp_pkg::DBGP_IDLE;
			end
			default: begin
				// Unused code falls back to idle
				rstate_next = dbgp_pkg::DBGP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rstate_reg <= dbgp_pkg::DBGP_IDLE;
			rwe_reg <= 1'b0;
			radr_reg <= dbgp_pkg::ADDR_ZERO;
			rdat_reg <= dbgp_pkg::DATA_ZERO;
			rrd_reg <= dbgp_pkg::DATA_ZERO;
		end else begin
			rstate_reg <= rstate_next;
			rwe_reg <= rwe_next;
			radr_reg <= radr_next;
			rdat_reg <= rdat_next;
			rrd_reg <= rrd_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// System bus master
	// Cycle attributes stay inside the bus master until ack or err ends the cycle
	dbgp_bus_master u_bus (
		// Clock and reset
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		// Requester side
		.req_valid(mem_req_valid),
		.req_ready(mem_req_ready),
		.req_write(mem_req_write),
		.req_addr(mem_req_addr),
		.req_sel(mem_req_sel),
		.req_wdata(mem_req_wdata),
		.rsp_valid(mem_rsp_valid),
		.rsp_err(mem_rsp_err),
		.rsp_rdata(mem_rsp_rdata),
		// Bus master side
		.wb_cyc_o(wb_cyc_o),
		.wb_stb_o(wb_stb_o),
		.wb_we_o(wb_we_o),
		.wb_adr_o(wb_adr_o),
		.wb_sel_o(wb_sel_o),
		.wb_dat_o(wb_dat_o),
		.wb_dat_i(wb_dat_i),
		.wb_ack_i(wb_ack_i),
		.wb_err_i(wb_err_i),
		.wb_cab_o(wb_cab_o),
		.wb_cti_o(wb_cti_o),
		.wb_bte_o(wb_bte_o)
	);
endmodule // dbgp_ports

/* sim/dbgp_ports_checker.sv */
// Concurrent checks on the debug port block, seen from its top-level ports only.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module dbgp_ports_checker (
	// Clock, reset and stall
	input wire logic clk_sys, sys_rst, stall_set, stall_clear, cpu_breakpoint_hit, cpu_stall,
	// Processor port
	input wire logic reg_req_valid, reg_req_ready, reg_req_write, reg_rsp_valid, cpu_stb, cpu_we, cpu_ack,
	input wire logic [dbgp_pkg::ADDR_W-1:0] reg_req_addr, cpu_adr, mem_req_addr, wb_adr_o,
	input wire logic [dbgp_pkg::DATA_W-1:0] cpu_dat_to, wb_dat_o,
	// Bus port
	input wire logic mem_req_valid, mem_req_ready, mem_rsp_valid, mem_rsp_err, wb_cyc_o, wb_stb_o, wb_we_o,
	input wire logic wb_ack_i, wb_err_i, wb_cab_o,
	input wire logic [dbgp_pkg::SEL_W-1:0] wb_sel_o,
	input wire logic [2:0] wb_cti_o,
	input wire logic [1:0] wb_bte_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_stall_set; (stall_set || cpu_breakpoint_hit) |=> cpu_stall; endproperty
	a_stall_set: assert property (p_stall_set) else $error("stall not raised");
	property p_stall_clr; stall_clear && !stall_set && !cpu_breakpoint_hit |=> !cpu_stall; endproperty
	a_stall_clr: assert property (p_stall_clr) else $error("stall not released");
	property p_cpu_start;
		reg_req_valid && reg_req_ready |=> cpu_stb && cpu_adr == $past(reg_req_addr) && cpu_we == $past(reg_req_write);
	endproperty
	a_cpu_start: assert property (p_cpu_start) else $error("register access not started");
	property p_cpu_hold;
		cpu_stb && !cpu_ack |=> cpu_stb && $stable(cpu_adr) && $stable(cpu_we) && $stable(cpu_dat_to);
	endproperty
	a_cpu_hold: assert property (p_cpu_hold) else $error("register request moved");
	property p_cpu_end; cpu_stb && cpu_ack |=> !cpu_stb && reg_rsp_valid; endproperty
	a_cpu_end: assert property (p_cpu_end) else $error("register access not ended");
	property p_wb_start; mem_req_valid && mem_req_ready |=> wb_cyc_o && wb_adr_o == $past(mem_req_addr); endproperty
	a_wb_start: assert property (p_wb_start) else $error("bus cycle not started");
	property p_wb_hold;
		wb_stb_o && !wb_ack_i && !wb_err_i |=> wb_stb_o && $stable({wb_adr_o, wb_we_o, wb_sel_o, wb_dat_o});
	endproperty
	a_wb_hold: assert property (p_wb_hold) else $error("bus request moved");
	property p_wb_end;
		wb_stb_o && (wb_ack_i || wb_err_i) |=> !wb_cyc_o && mem_rsp_valid && mem_rsp_err == $past(wb_err_i);
	endproperty
	a_wb_end: assert property (p_wb_end) else $error("bus cycle not single");
	property p_wb_const;
		wb_cyc_o == wb_stb_o && {wb_cab_o, wb_cti_o, wb_bte_o} == 6'h00;
	endproperty
	a_wb_const: assert property (p_wb_const) else $error("bus attributes wrong");
	c_wb_err: cover property (wb_stb_o && wb_err_i);
	c_cpu_wr: cover property (cpu_stb && cpu_ack && cpu_we);
	c_refused_clear: cover property (stall_clear && cpu_breakpoint_hit);
endmodule // dbgp_ports_checker

bind dbgp_ports dbgp_ports_checker u_chk (.clk_sys, .sys_rst, .stall_set, .stall_clear, .cpu_breakpoint_hit,
	.cpu_stall, .reg_req_valid, .reg_req_ready, .reg_req_write, .reg_rsp_valid, .cpu_stb, .cpu_we, .cpu_ack,
	.reg_req_addr, .cpu_adr, .mem_req_addr, .wb_adr_o, .cpu_dat_to, .wb_dat_o, .mem_req_valid, .mem_req_ready,
	.mem_rsp_valid, .mem_rsp_err, .wb_cyc_o, .wb_stb_o, .wb_we_o, .wb_ack_i, .wb_err_i, .wb_cab_o, .wb_sel_o,
	.wb_cti_o, .wb_bte_o);

/* sim/dbgp_far_model.sv */
// Model of the processor debug port and the bus slave behind the interconnect.
// Assumes the bench sets delay and error mode only between accesses.
`timescale 1ns/1ps
module dbgp_far_model (
	// Clock, reset and bench controls
	input wire logic clk_sys, sys_rst, wb_err_mode,
	input wire logic [1:0] delay,
	// Requests from the block
	input wire logic cpu_stb, wb_stb_o,
	input wire logic [31:0] cpu_adr, wb_adr_o,
	// Answers
	output logic cpu_ack, wb_ack_i, wb_err_i,
	output logic [31:0] cpu_dat_from, wb_dat_i
);
	// Watchpoint trigger held low, status outputs left open: no such pins here
	localparam logic EXT_TRIGGER = 1'b0;
	logic [1:0] cpu_cnt, wb_cnt;
	logic cpu_done, wb_done, wb_end, wb_hit;
	assign wb_end = wb_ack_i | wb_err_i;
	assign wb_hit = wb_stb_o && !wb_done && !wb_end && wb_cnt == delay;
	// Inverted outside the answer so stale data never passes
	assign cpu_dat_from = cpu_adr ^ 32'h5A5A_C3C3 ^ {32{~cpu_ack}};
	assign wb_dat_i = wb_adr_o ^ 32'h0F0F_F0F0 ^ {32{~wb_end}};
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			{cpu_ack, cpu_cnt, cpu_done, wb_ack_i, wb_err_i, wb_cnt, wb_done} <= '0;
		end else begin
			cpu_ack <= cpu_stb && !cpu_done && !cpu_ack && cpu_cnt == delay;
			cpu_cnt <= cpu_stb ? cpu_cnt + 2'h1 : 2'h0;
			cpu_done <= cpu_stb && (cpu_done || cpu_ack);
			wb_ack_i <= wb_hit && !wb_err_mode;
			wb_err_i <= wb_hit && wb_err_mode;
			wb_cnt <= wb_stb_o ? wb_cnt + 2'h1 : 2'h0;
			wb_done <= wb_stb_o && (wb_done || wb_end);
		end
	end
endmodule // dbgp_far_model

/* sim/dbgp_ports_test.sv */
// Self-checking bench for the debug processor and bus master ports.
// Assumes the far-side model answers with a bench-chosen delay.
`timescale 1ns/1ps
module dbgp_ports_test;
	logic clk_sys = 0, sys_rst = 1, stall_set = 0, stall_clear = 0, cpu_breakpoint_hit = 0, wb_err_mode = 0;
	logic reg_req_valid = 0, reg_req_write = 0, mem_req_valid = 0, mem_req_write = 0, exp_stall = 0;
	logic [31:0] reg_req_addr = '0, reg_req_wdata = '0, mem_req_addr = '0, mem_req_wdata = '0, r;
	logic [31:0] cpu_adr, cpu_dat_to, cpu_dat_from, wb_adr_o, wb_dat_o, wb_dat_i, reg_rsp_rdata, mem_rsp_rdata;
	logic [3:0] mem_req_sel = '0, wb_sel_o;
	logic [2:0] wb_cti_o;
	logic [1:0] wb_bte_o, delay = '0;
	logic stall_active, breakpoint_seen, reg_req_ready, reg_rsp_valid, mem_req_ready, mem_rsp_valid, mem_rsp_err;
	logic cpu_stall, cpu_stb, cpu_we, cpu_ack, wb_cyc_o, wb_stb_o, wb_we_o, wb_ack_i, wb_err_i, wb_cab_o;
	int seed = 49422, num_errors = 0, total_checks = 0;
	always #20 clk_sys = ~clk_sys;
	dbgp_ports DUT (.clk_sys, .sys_rst, .stall_set, .stall_clear, .stall_active, .breakpoint_seen, .reg_req_valid,
		.reg_req_ready, .reg_req_write, .reg_req_addr, .reg_req_wdata, .reg_rsp_valid, .reg_rsp_rdata, .mem_req_valid,
		.mem_req_ready, .mem_req_write, .mem_req_addr, .mem_req_sel, .mem_req_wdata, .mem_rsp_valid, .mem_rsp_err,
		.mem_rsp_rdata, .cpu_stall, .cpu_breakpoint_hit, .cpu_stb, .cpu_we, .cpu_adr, .cpu_dat_to, .cpu_dat_from,
		.cpu_ack, .wb_cyc_o, .wb_stb_o, .wb_we_o, .wb_adr_o, .wb_sel_o, .wb_dat_o, .wb_dat_i, .wb_ack_i, .wb_err_i,
		.wb_cab_o, .wb_cti_o, .wb_bte_o);
	dbgp_far_model u_far (.clk_sys, .sys_rst, .wb_err_mode, .delay, .cpu_stb, .wb_stb_o, .cpu_adr, .wb_adr_o,
		.cpu_ack, .wb_ack_i, .wb_err_i, .cpu_dat_from, .wb_dat_i);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Expected values: the stall rule and the far model's answer patterns
	function automatic logic exp_stall_after(input logic set_in, clr_in, bp_in, prev);
		return (set_in | bp_in) ? 1'b1 : clr_in ? 1'b0 : prev;
	endfunction
	function automatic logic [31:0] exp_rdata(input logic mem, input logic [31:0] a);
		return a ^ (mem ? 32'h0F0F_F0F0 : 32'h5A5A_C3C3);
	endfunction
	task automatic tally_and_finish;
		if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One request, held until taken, then the far side and the answer are checked
	task automatic access(input logic mem, wr, input logic [31:0] a, d, input logic [3:0] s);
		int n;
		n = 0;
		// Offer only when idle: a request made while busy is dropped
		while ((mem ? mem_req_ready : reg_req_ready) !== 1'b1) @(negedge clk_sys);
		if (mem) {mem_req_valid, mem_req_write, mem_req_addr, mem_req_sel, mem_req_wdata} = {1'b1, wr, a, s, d};
		else {reg_req_valid, reg_req_write, reg_req_addr, reg_req_wdata} = {1'b1, wr, a, d};
		@(negedge clk_sys);
		{mem_req_valid, reg_req_valid} = 2'b00;
		check(mem ? wb_adr_o : cpu_adr, a);
		check(32'(mem ? {wb_stb_o, wb_we_o, wb_sel_o} : {cpu_stb, cpu_we, s}), 32'({1'b1, wr, s}));
		check(mem ? wb_dat_o : cpu_dat_to, (wr || mem) ? d : 32'h0);
		while ((mem ? mem_rsp_valid : reg_rsp_valid) !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		check(32'(n < 20), 32'h1);
		if (mem) check(mem_rsp_rdata, exp_rdata(1'b1, a));
		if (mem) check(32'(mem_rsp_err), 32'(wb_err_mode));
		if (!mem && !wr) check(reg_rsp_rdata, exp_rdata(1'b0, a));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk_sys);
		sys_rst = 0;
		check(32'({reg_req_ready, mem_req_ready, cpu_stall, cpu_stb, wb_cyc_o}), 32'h18);
		for (int i = 0; i < 40; i++) begin
			{stall_set, stall_clear, cpu_breakpoint_hit} = 3'($random(seed));
			exp_stall = exp_stall_after(stall_set, stall_clear, cpu_breakpoint_hit, exp_stall);
			@(negedge clk_sys);
			check(32'(cpu_stall), 32'(exp_stall));
			check(32'(stall_active), 32'(exp_stall));
			check(32'(breakpoint_seen), 32'(cpu_breakpoint_hit));
		end
		{stall_set, stall_clear, cpu_breakpoint_hit} = 3'b000;
		// Corner addresses and both delay extremes first, then random traffic
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			delay = (i < 2) ? 2'(i * 3) : r[1:0];
			wb_err_mode = r[2] & (i > 3);
			access(r[3], r[4], (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : $random(seed), $random(seed), r[8:5]);
		end
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish();
	end
endmodule // dbgp_ports_test
